// ==== nrps_pkg.sv ====
// shared constants for the nand read/program sequencer
package nrps_pkg;
   localparam int          CLK_MHZ           = 20;
   localparam logic [7:0]  CMD_READ          = 8'h00;
   localparam logic [7:0]  CMD_READ_CONF     = 8'h30;
   localparam logic [7:0]  CMD_PART_CONF     = 8'h31;
   localparam logic [7:0]  CMD_RND_OUT       = 8'h05;
   localparam logic [7:0]  CMD_RND_OUT_CONF  = 8'he0;
   localparam logic [7:0]  CMD_SER_IN        = 8'h80;
   localparam logic [7:0]  CMD_RND_IN        = 8'h85;
   localparam logic [7:0]  CMD_PROG_CONF     = 8'h10;
   localparam logic [7:0]  CMD_CACHE_CONF    = 8'h15;
   localparam logic [7:0]  CMD_STATUS        = 8'h70;
   localparam logic [7:0]  CMD_RESET         = 8'hff;
   localparam int          COL_W             = 12;
   localparam int          ROW_W             = 16;
   localparam int          PAGE_BYTES        = 2112;
   localparam logic [11:0] COL_LAST_X8       = 12'h83f;
   localparam logic [11:0] COL_LAST_X16      = 12'h41f;
   localparam logic [11:0] SPARE_X8          = 12'h800;
   localparam logic [11:0] SPARE_X16         = 12'h400;
   localparam int          SEG_N             = 8;
   localparam int          ST_FAIL_CUR       = 0;
   localparam int          ST_FAIL_PREV      = 1;
   localparam int          ST_TRUE_RDY       = 5;
   localparam int          ST_CACHE_RDY      = 6;
   localparam int          ST_WP             = 7;
   localparam int          ADDR_CYCLES       = 4;
   // times in ns
   localparam int          LOAD_TIME_NS      = 1000;
   localparam int          CACHE_BUSY_NS     = 500;
   localparam int          PROG_TIME_NS      = 20000;
   localparam int          LOAD_CYC          = (LOAD_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int          CBSY_CYC          = (CACHE_BUSY_NS * CLK_MHZ + 999) / 1000;
   localparam int          PROG_CYC          = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int          CNT_W             = 16;
   typedef enum logic [1:0] {OUT_DATA, OUT_STATUS} nrps_out_e;
endpackage

// ==== nrps_sync.sv ====
// two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module nrps_sync #(parameter int W = 1) (
   input  wire logic         i_clk,  // clock
   input  wire logic         i_rst_n, // async reset
   input  wire logic [W-1:0] i_d,    // async input
   output logic      [W-1:0] o_q     // synchronised
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   // first stage is read by second stage only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= i_d;
         q_ff    <= meta_ff;
      end
   end
   assign o_q = q_ff;
endmodule

// ==== nrps_timer.sv ====
// loadable down counter that flags expiry
`timescale 1ns/1ps
module nrps_timer
   import nrps_pkg::*;
(
   input  wire logic             i_clk,   // clock
   input  wire logic             i_rst_n, // async reset
   input  wire logic             i_load,  // load pulse
   input  wire logic [CNT_W-1:0] i_count, // cycles to run
   output logic                  o_busy   // counting
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   always_comb begin
      nxt_cnt = cnt_ff;
      if (i_load)
         nxt_cnt = i_count;
      else if (cnt_ff != '0)
         nxt_cnt = cnt_ff - 1'b1;
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         cnt_ff <= '0;
      else
         cnt_ff <= nxt_cnt;
   end
   assign o_busy = (cnt_ff != '0);
endmodule

// ==== nrps_top.sv ====
// nand command sequencer: read, random output, page and cache program
`timescale 1ns/1ps
module nrps_top
   import nrps_pkg::*;
(
   input  wire logic        I_CLOCK,       // 20 MHz clock
   input  wire logic        I_RST_N,       // async reset, active low
   input  wire logic        I_CMD_LATCH,   // command latch enable pin
   input  wire logic        I_ADDR_LATCH,  // address latch enable pin
   input  wire logic        I_CHIP_SEL_N,  // chip select pin
   input  wire logic        I_WR_STROBE_N, // write strobe pin
   input  wire logic        I_READ_STROBE_N, // read strobe pin
   input  wire logic        I_WR_PROT_N,   // write protect pin
   input  wire logic        I_X16,         // bus width strap, 1 = x16
   input  wire logic [15:0] I_IO,          // io pins in
   input  wire logic        I_PROG_FAIL,   // array verify reports a stuck 1
   output logic      [15:0] O_IO,          // io pins out
   output logic             O_IO_OE_N,     // io enable, low = driving
   output logic             O_READY_BUSY_N, // ready_busy_n, 0 = busy
   output logic             O_ARRAY_PROG,  // array program pulse
   output logic [ROW_W-1:0] O_ROW,         // row being programmed
   output logic [SEG_N-1:0] O_SEG_MASK     // segments written this program
);
   // pins and straps synchronised before use; active-low select and strobe pins cross inverted (write protect does not)
   // so the flops' reset value reads as idle and no false edge follows reset
   logic [22:0] pin_s;
   nrps_sync #(.W(23)) u_sync (
      .i_clk  (I_CLOCK),
      .i_rst_n(I_RST_N),
      .i_d    ({I_CMD_LATCH, I_ADDR_LATCH, ~I_CHIP_SEL_N, ~I_WR_STROBE_N, ~I_READ_STROBE_N,
                I_WR_PROT_N, I_X16, I_IO}),
      .o_q    (pin_s)
   );
   logic cle, ale, ce, we, re, ce_n, we_n, re_n, wr_prot_n, x16_mode;
   logic [15:0] io_s;
   assign {cle, ale, ce, we, re, wr_prot_n, x16_mode, io_s} = pin_s;
   assign ce_n = ~ce;
   assign we_n = ~we;
   assign re_n = ~re;

   typedef enum logic [2:0] {S_IDLE, S_RD_ADDR, S_RD_COL, S_PG_ADDR, S_PG_DATA, S_ABORT} nrps_state_e;

   logic        we_d_ff, re_d_ff;
   logic        we_rise, re_fall;
   logic [7:0]  cmd;
   // edges seen only on synchronised copies
   assign we_rise = we_n & ~we_d_ff & ~ce_n;
   assign re_fall = ~re_n & re_d_ff & ~ce_n;
   assign cmd     = io_s[7:0];

   // page store and cache (x8 bytes, x16 uses low half of indices)
   logic [15:0] page_mem  [PAGE_BYTES];
   logic [15:0] cache_mem [PAGE_BYTES];

   nrps_state_e      st_ff, nxt_st;
   nrps_out_e        out_ff, nxt_out;
   logic [1:0]       acnt_ff, nxt_acnt;
   logic [COL_W-1:0] col_ff, nxt_col;
   logic [ROW_W-1:0] row_ff, nxt_row;
   logic [ROW_W-1:0] prow_ff, nxt_prow;
   logic [SEG_N-1:0] seg_ff, nxt_seg;
   logic             cache_ff, nxt_cache;
   logic             pend_ff, nxt_pend;
   logic             fcur_ff, nxt_fcur;
   logic             fprev_ff, nxt_fprev;
   logic             pgm_ff, nxt_pgm;
   logic             ld_go, cb_go, pg_go;
   logic             ld_busy, cb_busy, pg_busy;
   logic             wr_cache, xfer;
   logic [COL_W-1:0] col_last;
   logic [COL_W-1:0] spare;

   assign col_last = x16_mode ? COL_LAST_X16 : COL_LAST_X8;
   assign spare    = x16_mode ? SPARE_X16 : SPARE_X8;

   nrps_timer u_ld (.i_clk(I_CLOCK), .i_rst_n(I_RST_N), .i_load(ld_go),
                    .i_count(CNT_W'(LOAD_CYC)), .o_busy(ld_busy));
   nrps_timer u_cb (.i_clk(I_CLOCK), .i_rst_n(I_RST_N), .i_load(cb_go),
                    .i_count(CNT_W'(CBSY_CYC)), .o_busy(cb_busy));
   nrps_timer u_pg (.i_clk(I_CLOCK), .i_rst_n(I_RST_N), .i_load(pg_go),
                    .i_count(CNT_W'(PROG_CYC)), .o_busy(pg_busy));

   logic cache_busy, true_busy;
   // a plain program keeps the cache tied up until the array is done
   assign cache_busy = ld_busy | cb_busy | pend_ff | (pg_busy & ~cache_ff);
   assign true_busy  = cache_busy | pg_busy;
   // transfer of queued cache waits for array to finish
   assign xfer       = pend_ff & ~pg_busy & ~cb_busy;

   // segment index of a column
   function automatic logic [2:0] seg_of(input logic [COL_W-1:0] c, input logic x16);
      logic [COL_W-1:0] off;
      off = c;
      if (c >= (x16 ? SPARE_X16 : SPARE_X8)) begin
         off = c - (x16 ? SPARE_X16 : SPARE_X8);
         seg_of = {1'b1, x16 ? off[4:3] : off[5:4]};
      end else begin
         seg_of = {1'b0, x16 ? c[9:8] : c[10:9]};
      end
   endfunction

   // command decoder and sequencer
   always_comb begin
      nxt_st    = st_ff;
      nxt_out   = out_ff;
      nxt_acnt  = acnt_ff;
      nxt_col   = col_ff;
      nxt_row   = row_ff;
      nxt_prow  = prow_ff;
      nxt_seg   = seg_ff;
      nxt_cache = cache_ff;
      nxt_pend  = pend_ff;
      nxt_fcur  = fcur_ff;
      nxt_fprev = fprev_ff;
      nxt_pgm   = 1'b0;
      ld_go     = 1'b0;
      cb_go     = 1'b0;
      pg_go     = 1'b0;
      wr_cache  = 1'b0;
      // array program outcome latched during the program pulse, at the edge that ends it
      if (pgm_ff) begin
         nxt_fcur = I_PROG_FAIL;
      end
      if (xfer) begin
         nxt_pend  = 1'b0;
         nxt_fprev = fcur_ff;
         nxt_pgm   = 1'b1;
         pg_go     = 1'b1;
         nxt_prow  = row_ff;
      end
      if (we_rise && cle) begin
         if (cmd == CMD_RESET) begin
            nxt_st   = S_IDLE;
            nxt_out  = OUT_DATA;
            nxt_pend = 1'b0;
         end else if (cmd == CMD_STATUS) begin
            nxt_out = OUT_STATUS;
         end else if (true_busy && !(cache_ff && !cache_busy)) begin
            nxt_st = st_ff;
         end else begin
            unique case (st_ff)
               S_PG_ADDR, S_PG_DATA: begin
                  if (cmd == CMD_PROG_CONF && !pg_busy) begin
                     nxt_st    = S_IDLE;
                     nxt_out   = OUT_STATUS;
                     nxt_cache = 1'b0;
                     nxt_pend  = 1'b1;
                  end else if (cmd == CMD_PROG_CONF || cmd == CMD_CACHE_CONF) begin
                     nxt_st    = S_IDLE;
                     nxt_out   = OUT_STATUS;
                     nxt_cache = (cmd == CMD_CACHE_CONF);
                     nxt_pend  = 1'b1;
                     cb_go     = 1'b1;
                  end else if (cmd == CMD_RND_IN) begin
                     nxt_st   = S_PG_ADDR;
                     nxt_acnt = '0;
                  end else begin
                     nxt_st = S_ABORT;
                  end
               end
               S_ABORT: nxt_st = S_ABORT;
               S_RD_ADDR: begin
                  if (cmd == CMD_READ_CONF || cmd == CMD_PART_CONF) begin
                     nxt_st  = S_IDLE;
                     nxt_out = OUT_DATA;
                     ld_go   = 1'b1;
                  end else if (cmd == CMD_RND_OUT_CONF) begin
                     nxt_st  = S_IDLE;
                     nxt_out = OUT_DATA;
                  end else begin
                     nxt_st = S_IDLE;
                  end
               end
               default: begin
                  nxt_out  = OUT_DATA;
                  nxt_acnt = '0;
                  if (cmd == CMD_READ || cmd == CMD_RND_OUT)
                     nxt_st = S_RD_ADDR;
                  else if (cmd == CMD_SER_IN) begin
                     nxt_st  = S_PG_ADDR;
                     nxt_seg = '0;
                  end else
                     nxt_st = S_IDLE;
               end
            endcase
         end
      end else if (we_rise && ale && (st_ff == S_RD_ADDR || st_ff == S_PG_ADDR || st_ff == S_PG_DATA)) begin
         // column in cycles 0-1, row in cycles 2-3; 05h/85h may stop after column
         unique case (acnt_ff)
            2'd0: nxt_col[7:0] = io_s[7:0];
            2'd1: nxt_col[COL_W-1:8] = x16_mode ? {1'b0, io_s[2:0]} : io_s[3:0];
            2'd2: nxt_row[7:0] = io_s[7:0];
            2'd3: nxt_row[15:8] = io_s[7:0];
         endcase
         nxt_acnt = acnt_ff + 2'd1;
         if (st_ff == S_PG_ADDR && acnt_ff == 2'(ADDR_CYCLES - 1))
            nxt_st = S_PG_DATA;
         if (st_ff == S_PG_ADDR && acnt_ff == 2'd1)
            nxt_st = S_PG_DATA;
      end else if (we_rise && !cle && !ale && (st_ff == S_PG_DATA || st_ff == S_PG_ADDR)) begin
         wr_cache = 1'b1;
         nxt_seg[seg_of(col_ff, x16_mode)] = 1'b1;
         if (col_ff != col_last)
            nxt_col = col_ff + 1'b1;
      end else if (re_fall && out_ff == OUT_DATA && !true_busy) begin
         if (col_ff != col_last)
            nxt_col = col_ff + 1'b1;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_ff    <= S_IDLE;
         out_ff   <= OUT_DATA;
         acnt_ff  <= '0;
         col_ff   <= '0;
         row_ff   <= '0;
         prow_ff  <= '0;
         seg_ff   <= '0;
         cache_ff <= 1'b0;
         pend_ff  <= 1'b0;
         fcur_ff  <= 1'b0;
         fprev_ff <= 1'b0;
         pgm_ff   <= 1'b0;
         we_d_ff  <= 1'b1;
         re_d_ff  <= 1'b1;
      end else begin
         st_ff    <= nxt_st;
         out_ff   <= nxt_out;
         acnt_ff  <= nxt_acnt;
         col_ff   <= nxt_col;
         row_ff   <= nxt_row;
         prow_ff  <= nxt_prow;
         seg_ff   <= nxt_seg;
         cache_ff <= nxt_cache;
         pend_ff  <= nxt_pend;
         fcur_ff  <= nxt_fcur;
         fprev_ff <= nxt_fprev;
         pgm_ff   <= nxt_pgm;
         we_d_ff  <= we_n;
         re_d_ff  <= re_n;
      end
   end

   // storage; no reset so it maps to ram
   always_ff @(posedge I_CLOCK) begin
      if (wr_cache)
         cache_mem[col_ff] <= io_s;
      if (xfer)
         page_mem <= cache_mem;
   end

   // status byte built from live state
   logic [7:0] status;
   always_comb begin
      status = '0;
      status[ST_FAIL_CUR]  = fcur_ff;
      status[ST_FAIL_PREV] = cache_ff & fprev_ff;
      status[ST_TRUE_RDY]  = ~true_busy;
      status[ST_CACHE_RDY] = ~cache_busy;
      status[ST_WP]        = wr_prot_n;
   end

   // registered pin drivers
   logic [15:0] io_ff, nxt_io;
   logic        oe_n_ff, nxt_oe_n;
   logic        rb_ff, nxt_rb;
   always_comb begin
      nxt_oe_n = ~(~ce_n & ~re_n);
      // data latched at the strobe fall, before the column moves on
      nxt_io   = io_ff;
      if (out_ff == OUT_STATUS)
         nxt_io = {8'h00, status};
      else if (re_fall)
         nxt_io = page_mem[col_ff];
      // pending cache transfer keeps the pin busy too
      nxt_rb   = ~cache_busy;
   end
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         io_ff   <= '0;
         oe_n_ff <= 1'b1;
         rb_ff   <= 1'b1;
      end else begin
         io_ff   <= nxt_io;
         oe_n_ff <= nxt_oe_n;
         rb_ff   <= nxt_rb;
      end
   end
   assign O_IO           = io_ff;
   assign O_IO_OE_N      = oe_n_ff;
   assign O_READY_BUSY_N = rb_ff;
   assign O_ARRAY_PROG   = pgm_ff;
   assign O_ROW          = prow_ff;
   assign O_SEG_MASK     = seg_ff;

   a_drive_window: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      !O_IO_OE_N |-> $past(~ce_n & ~re_n)) else $error("io driven outside read window");
   a_busy_cmd: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (we_rise && cle && cmd == CMD_READ && true_busy && !cache_ff) |=> st_ff == $past(st_ff))
      else $error("command taken while busy");
   a_read_load: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (ld_go) |=> ##1 !O_READY_BUSY_N) else $error("page load not busy");
   a_col_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (re_fall && out_ff == OUT_DATA && col_ff == col_last && st_ff == S_IDLE) |=> col_ff == col_last)
      else $error("column ran past end");
   a_abort_sticky: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (st_ff == S_ABORT && !(we_rise && cle && cmd == CMD_RESET)) |=> st_ff == S_ABORT)
      else $error("abort left without reset");
   a_xfer_wait: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      O_ARRAY_PROG |-> !$past(pg_busy)) else $error("transfer during program");
   a_prog_busy: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      $rose(O_ARRAY_PROG) |-> ##2 status[ST_TRUE_RDY] == 1'b0) else $error("true ready wrong");
   a_status_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (out_ff == OUT_STATUS && !(we_rise && cle)) |=> out_ff == OUT_STATUS)
      else $error("status mode dropped");
   c_page_read: cover property (@(posedge I_CLOCK) ld_go);
   c_cache_prog: cover property (@(posedge I_CLOCK) cb_go && cache_ff == 1'b0 ##1 cache_ff);
   c_abort: cover property (@(posedge I_CLOCK) st_ff == S_ABORT);
endmodule

// ==== nrps_host_model.sv ====
// host flash controller model driving the pin side of the sequencer
`timescale 1ns/1ps
module nrps_host_model (
   input  wire logic        i_clk,   // clock
   input  wire logic [15:0] i_io,    // resolved bus level
   input  wire logic        i_oe_n,  // device drive enable
   input  wire logic        i_rb_n,  // ready_busy_n pin
   output logic             o_cle,   // command latch
   output logic             o_ale,   // address latch
   output logic             o_ce_n,  // chip select
   output logic             o_we_n,  // write strobe
   output logic             o_re_n,  // read_strobe_n
   output logic [15:0]      o_io,    // bus value, inverted once released
   output logic             o_io_en  // host drives the bus
);
   // pins idle until the first cycle
   initial begin
      {o_cle, o_ale, o_io_en} = 3'h0;
      {o_ce_n, o_we_n, o_re_n} = 3'h7;
      o_io = 16'h0000;
   end

   // four clocks a level, two more than the pin synchroniser needs
   task automatic hold();
      repeat (4) @(posedge i_clk);
   endtask

   // one latched write cycle, its kind set by the latch pins
   task automatic wr(input logic cl, input logic al, input logic [15:0] val);
      {o_cle, o_ale, o_ce_n, o_io_en} <= {cl, al, 2'b01};
      o_io <= val;
      hold();
      o_we_n <= 1'b0;
      hold();
      o_we_n <= 1'b1;
      hold();
      {o_cle, o_ale, o_io_en} <= 3'h0;
      o_io <= ~val; // released bus must not keep the old value
      @(posedge i_clk);
   endtask

   // read cycle: strobe low long enough for the drive enable to land
   task automatic rd(output logic [15:0] val, output logic oe);
      o_re_n <= 1'b0;
      hold();
      hold();
      val = i_io;
      oe = i_oe_n;
      o_re_n <= 1'b1;
      hold();
      @(posedge i_clk);
   endtask

   // bounded wait on ready_busy_n before data is clocked out
   task automatic wait_rdy(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 2000 && !ok; i++) begin
         @(posedge i_clk);
         ok = i_rb_n;
      end
   endtask
endmodule

// ==== tb_nand_read_program_sequencer.sv ====
// self-checking bench for the nand command sequencer
`timescale 1ns/1ps
module tb_nand_read_program_sequencer;
   import nrps_pkg::*;
   logic        clk, rst_n, wp_n, x16, fail, oe, ok;
   logic        cle, ale, ce_n, we_n, re_n, h_en, oe_n, rb_n, aprog;
   logic [15:0] h_io, bus, o_io, v, row_o;
   logic [7:0]  seg, exp_seg;
   int          err_count = 0;
   int          samples_checked = 0;
   int          prog_cnt = 0;
   int          cyc = 0;
   int          row, col, mem[int];
   int unsigned seed;

   // bus level: host, else device when enabled, else the host's scrambled value
   assign bus = (h_en || oe_n) ? h_io : o_io;

   nrps_top nrps_top_inst (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CMD_LATCH(cle), .I_ADDR_LATCH(ale),
      .I_CHIP_SEL_N(ce_n), .I_WR_STROBE_N(we_n), .I_READ_STROBE_N(re_n), .I_WR_PROT_N(wp_n),
      .I_X16(x16), .I_IO(bus), .I_PROG_FAIL(fail), .O_IO(o_io), .O_IO_OE_N(oe_n),
      .O_READY_BUSY_N(rb_n), .O_ARRAY_PROG(aprog), .O_ROW(row_o), .O_SEG_MASK(seg));

   nrps_host_model nrps_host_model_inst (.i_clk(clk), .i_io(bus), .i_oe_n(oe_n), .i_rb_n(rb_n),
      .o_cle(cle), .o_ale(ale), .o_ce_n(ce_n), .o_we_n(we_n), .o_re_n(re_n), .o_io(h_io),
      .o_io_en(h_en));

   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // count program pulses; cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (aprog === 1'b1) prog_cnt <= prog_cnt + 1;
      if (cyc == 30000) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask

   task automatic report_and_stop();
      if (err_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // segment index of a column in the current bus width
   function automatic int seg_of(input int c);
      int sp;
      sp = x16 ? 1024 : 2048;
      return (c >= sp) ? 4 + (c - sp) / (x16 ? 8 : 16) : c / (x16 ? 256 : 512);
   endfunction

   task automatic c(input logic [7:0] x);
      nrps_host_model_inst.wr(1'b1, 1'b0, {8'h00, x});
   endtask

   // address cycles: column low, column high, row low, row high
   task automatic a(input int cl, input int rw, input int n);
      logic [31:0] ad;
      ad = {rw[15:0], cl[15:0]};
      for (int i = 0; i < n; i++) nrps_host_model_inst.wr(1'b0, 1'b1, {8'h00, ad[8*i +: 8]});
   endtask

   // one random data byte, recorded in the page model
   task automatic w(input int cl);
      logic [7:0] d;
      d = 8'($urandom);
      nrps_host_model_inst.wr(1'b0, 1'b0, {8'h00, d});
      mem[cl] = d;
      exp_seg[seg_of(cl)] = 1'b1;
   endtask

   task automatic r(input string n, input logic [15:0] e, input logic [15:0] m);
      nrps_host_model_inst.rd(v, oe);
      chk("drive_on", {15'h0, oe}, 16'h0000);
      chk(n, v & m, e);
      chk("drive_off", {15'h0, oe_n}, 16'h0001);
   endtask

   task automatic rdy();
      nrps_host_model_inst.wait_rdy(ok);
      chk("ready", {15'h0, ok}, 16'h0001);
   endtask

   initial begin
      {rst_n, x16, fail} = 3'h0;
      wp_n = 1'b1;
      exp_seg = 8'h00;
      seed = $urandom(95);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("rb_idle", {15'h0, rb_n}, 16'h0001);
      chk("oe_idle", {15'h0, oe_n}, 16'h0001);
      c(CMD_STATUS);
      r("st_reset", 16'h00e0, 16'h00e4);
      r("st_again", 16'h00e0, 16'h00e4);
      // program with a column jump into the last spare segment
      row = $urandom_range(0, 200);
      col = $urandom_range(0, 500);
      c(CMD_SER_IN);
      a(col, row, 4);
      w(col);
      w(col + 1);
      c(CMD_RND_IN);
      a(12'h83d, 0, 2);
      for (int i = 12'h83d; i <= 12'h83f; i++) w(i);
      chk("segs", {8'h0, seg}, {8'h0, exp_seg});
      c(CMD_PROG_CONF);
      chk("prog_busy", {15'h0, rb_n}, 16'h0000);
      c(CMD_READ); // ignored while busy
      c(CMD_STATUS);
      r("st_busy", 16'h0080, 16'h00e0);
      rdy();
      r("st_done", 16'h00e0, 16'h00e1);
      chk("row", row_o, row[15:0]);
      chk("pulses", 16'(prog_cnt), 16'h0001);
      // sequential read, random output, hold at last column
      c(CMD_READ);
      a(col, row, 4);
      c(CMD_READ_CONF);
      chk("load_busy", {15'h0, rb_n}, 16'h0000);
      rdy();
      r("rd0", 16'(mem[col]), 16'h00ff);
      r("rd1", 16'(mem[col + 1]), 16'h00ff);
      c(CMD_RND_OUT);
      a(12'h83e, 0, 2);
      c(CMD_RND_OUT_CONF);
      r("rd2", 16'(mem[12'h83e]), 16'h00ff);
      r("rd3", 16'(mem[12'h83f]), 16'h00ff);
      r("rd4", 16'(mem[12'h83f]), 16'h00ff);
      c(CMD_READ);
      a(12'h83d, row, 4);
      c(CMD_PART_CONF);
      rdy();
      r("rd5", 16'(mem[12'h83d]), 16'h00ff);
      // two cache pages on fresh rows, the first failing verify
      fail <= 1'b1;
      c(CMD_SER_IN);
      a(0, row + 1, 4);
      w(0);
      c(CMD_CACHE_CONF);
      rdy();
      fail <= 1'b0; // page one was sampled at the edge that ends its pulse
      c(CMD_STATUS);
      r("st_cache", 16'h0040, 16'h0060);
      c(CMD_SER_IN);
      a(0, row + 2, 4);
      w(0);
      c(CMD_CACHE_CONF);
      repeat (20) @(posedge clk);
      chk("cache_wait", {15'h0, rb_n}, 16'h0000);
      rdy();
      c(CMD_STATUS);
      r("st_prev", 16'h0042, 16'h0042);
      for (int i = 0; i < 40 && v[5] !== 1'b1; i++) nrps_host_model_inst.rd(v, oe);
      r("st_true", 16'h0060, 16'h0061);
      chk("pulses3", 16'(prog_cnt), 16'h0003);
      // x16 spare column, then a wrong code aborts the program
      x16 <= 1'b1;
      exp_seg = 8'h00;
      c(CMD_SER_IN);
      a(12'h400, row + 3, 4);
      w(12'h400);
      chk("segs16", {8'h0, seg}, {8'h0, exp_seg});
      c(CMD_READ);
      c(CMD_PROG_CONF);
      chk("no_prog", {15'h0, rb_n}, 16'h0001);
      chk("pulses4", 16'(prog_cnt), 16'h0003);
      c(CMD_RESET);
      c(CMD_STATUS);
      r("st_after", 16'h00e0, 16'h00e0);
      report_and_stop();
   end
endmodule
